// ==== inc/pabw_pkg.sv ====
// Constants and carrier types for the per-area bus width and byte order block.
// Assumes a 100 MHz APB clock and eight chip-select areas.
package pabw_pkg;

   // ****************************************************************
   // Geometry
   // ****************************************************************
   localparam int AREAS = 8;
   localparam int REG_W = 16;

   // ****************************************************************
   // Register map (printed offsets, word index is offset / 4 when odd)
   // ****************************************************************
   localparam logic [31:0] BYTE_ORDER_CONFIG_IDX = 32'h0FFF_F668;
   localparam logic [31:0] BUS_WIDTH_CONFIG_IDX = 32'hFFFF_F066;
   localparam logic [11:0] BYTE_ORDER_CONFIG_ADDR = 12'h9A0;
   localparam logic [11:0] BUS_WIDTH_CONFIG_ADDR = 12'h198;

   // ****************************************************************
   // Field layout and reset values
   // ****************************************************************
   localparam logic [15:0] BYTE_ORDER_MASK = 16'h5555;
   localparam logic [15:0] BYTE_ORDER_RESET = 16'h0000;
   localparam logic [15:0] WIDTH_RESET_32 = 16'hAAAA;
   localparam logic [15:0] WIDTH_RESET_16 = 16'h5555;
   localparam logic [15:0] WIDTH_RESET_8 = 16'h0000;
   localparam logic [3:0] HALFWORD_STRB = 4'h3;

   // ****************************************************************
   // Width codes
   // ****************************************************************
   typedef enum logic [1:0] {
      PABW_W8 = 2'h0,
      PABW_W16 = 2'h1,
      PABW_W32 = 2'h2,
      PABW_WBAD = 2'h3
   } pabw_width_type;

   // ****************************************************************
   // System bus access carriers
   // ****************************************************************
   typedef struct packed {
      logic [7:0] chip_select_area;
      logic fixed_little_area;
      logic external_fetch_strobe;
   } pabw_acc_type;

   typedef struct packed {
      pabw_width_type width;
      logic big_endian;
      logic bad_width;
   } pabw_cfg_type;

endpackage

// ==== hdl/pabw_sync.sv ====
// Two flip-flop synchroniser for a group of level inputs.
// Assumes the inputs may change at any time against pclk.
`timescale 1ns/10ps
module pabw_sync #(
   parameter int W = 2
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Data
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_q;

   // Two stages; first stage read only by second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= '0;
         sync_out <= '0;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule

// ==== hdl/pabw_swap.sv ====
// Byte lane steering of one word for the selected byte order.
// Assumes the lane at the lowest address is bits 7..0 when little endian.
`timescale 1ns/10ps
module pabw_swap (
   // Control
   input wire logic big_endian,
   // Data
   input wire logic [31:0] word_in,
   output logic [31:0] word_out
);
   // ****************************************************************
   // Lane steering, one generate per byte
   // ****************************************************************
   genvar b;
   generate
      for (b = 0; b < 4; b++) begin : g_lane
         // Little keeps the lane; big mirrors it
         assign word_out[8*b +: 8] = big_endian ? word_in[8*(3-b) +: 8] : word_in[8*b +: 8];
      end
   endgenerate
endmodule

// ==== hdl/pabw_config.sv ====
// Per-area bus width and byte order configuration with APB access.
// Assumes a single pclk domain and boot width straps that are stable around reset.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/10ps
module pabw_config
   import pabw_pkg::*;
(
   // APB clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Boot width straps
   input wire logic boot_width_strap_high,
   input wire logic boot_width_strap_low,
   // System bus access
   input wire pabw_pkg::pabw_acc_type acc,
   input wire logic [31:0] acc_wdata,
   input wire logic [31:0] acc_rdata,
   output pabw_pkg::pabw_cfg_type cfg,
   output logic [31:0] bus_wdata,
   output logic [31:0] core_rdata
);
   import pabw_pkg::*;

   // ****************************************************************
   // Strap capture
   // ****************************************************************
   logic [1:0] strap_sync;
   logic strap_done_q;
   logic [15:0] strap_pattern;

   pabw_sync #(.W(2)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in({boot_width_strap_high, boot_width_strap_low}),
      .sync_out(strap_sync)
   );

   // Strap pattern select; 11 falls back to 32-bit
   assign strap_pattern = (strap_sync == 2'h1) ? WIDTH_RESET_16 :
                          (strap_sync == 2'h2) ? WIDTH_RESET_8 : WIDTH_RESET_32;

   // ****************************************************************
   // APB decode
   // ****************************************************************
   logic access_ph;
   logic hit_width;
   logic hit_order;
   logic full_half;
   logic wr_width;
   logic wr_order;

   assign access_ph = psel && penable;
   assign hit_width = paddr[11:0] == BUS_WIDTH_CONFIG_ADDR;
   assign hit_order = paddr[11:0] == BYTE_ORDER_CONFIG_ADDR;
   assign full_half = pstrb == HALFWORD_STRB;
   assign wr_width = access_ph && pwrite && hit_width && full_half;
   assign wr_order = access_ph && pwrite && hit_order && full_half;
   assign pready = 1'b1;
   assign pslverr = access_ph && (!(hit_width || hit_order) || (pwrite && !full_half));

   // ****************************************************************
   // Registers
   // ****************************************************************
   logic [15:0] width_q;
   logic [15:0] width_d;
   logic [15:0] order_q;
   logic [15:0] order_d;
   logic [31:0] prdata_d;

   // Width loads strap pattern on each edge until strap capture is done, then software
   assign width_d = !strap_done_q ? strap_pattern : wr_width ? pwdata[15:0] : width_q;
   assign order_d = wr_order ? (pwdata[15:0] & BYTE_ORDER_MASK) : order_q;

   // Read mux
   assign prdata_d = hit_width ? {16'h0000, width_q} :
                     hit_order ? {16'h0000, order_q & BYTE_ORDER_MASK} : 32'h0000_0000;

   // Strap capture waits two edges for the synchroniser to fill, then loads at the third
   logic strap_wait_q;
   logic strap_fill_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_wait_q <= 1'b0;
         strap_fill_q <= 1'b0;
         strap_done_q <= 1'b0;
      end else begin
         strap_wait_q <= 1'b1;
         strap_fill_q <= strap_wait_q;
         strap_done_q <= strap_done_q | strap_fill_q;
      end
   end

   // Configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         width_q <= WIDTH_RESET_32;
         order_q <= BYTE_ORDER_RESET;
         prdata <= 32'h0000_0000;
      end else begin
         width_q <= width_d;
         order_q <= order_d;
         prdata <= (psel && !penable && !pwrite) ? prdata_d : prdata;
      end
   end

   // ****************************************************************
   // Per-area selection
   // ****************************************************************
   logic [1:0] area_width [AREAS];
   logic [AREAS-1:0] area_big_endian_bit;
   logic [1:0] width_or;
   logic big_or;

   genvar n;
   generate
      for (n = 0; n < AREAS; n++) begin : g_area
         assign area_width[n] = width_q[2*n +: 2];
         assign area_big_endian_bit[n] = order_q[2*n];
      end
   endgenerate

   // Active chip select picks its area's fields
   always_comb begin
      width_or = 2'h0;
      big_or = 1'b0;
      for (int i = 0; i < AREAS; i++) begin
         if (acc.chip_select_area[i]) begin
            width_or = width_or | area_width[i];
            big_or = big_or | area_big_endian_bit[i];
         end
      end
   end

   logic eff_big;
   // Fixed areas and fetches force little endian
   assign eff_big = big_or && !acc.fixed_little_area && !acc.external_fetch_strobe;

   assign cfg.width = pabw_width_type'(width_or);
   assign cfg.big_endian = eff_big;
   assign cfg.bad_width = width_or == PABW_WBAD;

   // ****************************************************************
   // Data steering
   // ****************************************************************
   pabw_swap u_wswap (
      .big_endian(eff_big),
      .word_in(acc_wdata),
      .word_out(bus_wdata)
   );

   pabw_swap u_rswap (
      .big_endian(eff_big),
      .word_in(acc_rdata),
      .word_out(core_rdata)
   );
endmodule

// ==== testbench/pabw_mem_model.sv ====
// Memory on the system bus for the byte order block.
// Assumes one-hot area selects; nothing selected drives the inverse of the last bus value.
`timescale 1ns/10ps
module pabw_mem_model
   import pabw_pkg::*;
(
   // Clock
   input wire logic pclk,
   // Access and read data
   input wire pabw_pkg::pabw_acc_type acc,
   output logic [31:0] acc_rdata
);
   logic [31:0] last_q;
   // Selected area answers a word naming it; idle bus shows the inverse of the last word
   assign acc_rdata = (|acc.chip_select_area) ? {acc.chip_select_area, 16'h3C5A, ~acc.chip_select_area} : ~last_q;
   // Remember the last bus value
   always_ff @(posedge pclk) begin
      last_q <= acc_rdata;
   end
endmodule

// ==== testbench/pabw_checker.sv ====
// Port checker for the per-area width and byte order block.
// Assumes one pclk domain and the block's APB port.
`timescale 1ns/10ps
module pabw_checker
   import pabw_pkg::*;
(
   // Clock, reset and APB
   input wire logic pclk, presetn, psel, penable, pwrite, pslverr,
   input wire logic [31:0] paddr, pwdata, prdata,
   input wire logic [3:0] pstrb,
   // System bus
   input wire pabw_pkg::pabw_acc_type acc,
   input wire pabw_pkg::pabw_cfg_type cfg,
   input wire logic [31:0] acc_wdata, bus_wdata
);
   // ****************************************************************
   // Properties
   // ****************************************************************
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_rd_hi; psel && penable && !pwrite |-> prdata[31:16] == 16'h0000; endproperty
   property p_odd; psel && penable && !pwrite && paddr[11:0] == BYTE_ORDER_CONFIG_ADDR
      |-> (prdata[15:0] & ~BYTE_ORDER_MASK) == 16'h0000; endproperty
   property p_strb; psel && penable && pwrite && pstrb != HALFWORD_STRB |-> pslverr; endproperty
   property p_le; !cfg.big_endian |-> bus_wdata == acc_wdata; endproperty
   property p_be; cfg.big_endian |-> bus_wdata == {acc_wdata[7:0], acc_wdata[15:8], acc_wdata[23:16], acc_wdata[31:24]};
   endproperty
   property p_fix; acc.fixed_little_area |-> !cfg.big_endian; endproperty
   property p_fetch; acc.external_fetch_strobe |-> !cfg.big_endian; endproperty
   property p_bad; cfg.bad_width == (cfg.width == PABW_WBAD); endproperty
   property p_wr; psel && penable && pwrite && paddr[11:0] == BYTE_ORDER_CONFIG_ADDR && pstrb == HALFWORD_STRB
      ##1 acc == 10'h004 |-> cfg.big_endian == $past(pwdata[0]); endproperty
   a_rd_hi: assert property (p_rd_hi) else $error("upper read half not zero");
   a_odd: assert property (p_odd) else $error("odd order bit set");
   a_strb: assert property (p_strb) else $error("partial write not refused");
   a_le: assert property (p_le) else $error("little lanes wrong");
   a_be: assert property (p_be) else $error("big lanes wrong");
   a_fix: assert property (p_fix) else $error("fixed area swapped");
   a_fetch: assert property (p_fetch) else $error("fetch swapped");
   a_bad: assert property (p_bad) else $error("bad width flag wrong");
   a_wr: assert property (p_wr) else $error("order write not applied");
   c_be: cover property (cfg.big_endian);
   c_err: cover property (pslverr);
   c_bad: cover property (cfg.bad_width);
endmodule
bind pabw_config pabw_checker chk (.pclk, .presetn, .psel, .penable, .pwrite, .pslverr, .paddr, .pwdata, .prdata,
   .pstrb, .acc, .cfg, .acc_wdata, .bus_wdata);

// ==== testbench/tb_top.sv ====
// Self-checking bench for the per-area width and byte order block.
// Assumes straps low/high, so widths reset to 16 bits.
`timescale 1ns/10ps
module tb_top;
   import pabw_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, bus_chk = 0, pready, pslverr, b;
   logic [31:0] paddr = 0, pwdata = 0, acc_wdata = 0, acc_rdata, prdata, bus_wdata, core_rdata, d;
   logic [3:0] pstrb = 0;
   pabw_acc_type acc = 10'h004;
   pabw_cfg_type cfg;
   logic [15:0] wv = 16'hE4E4, ov;
   logic [31:0] rd_q[$];
   logic [35:0] bq[$];
   logic [35:0] x;
   int error_cnt = 0, samples_checked = 0, cyc = 0;
   always #5 pclk = ~pclk;
   pabw_config uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
      .boot_width_strap_high(1'b0), .boot_width_strap_low(1'b1), .acc, .acc_wdata, .acc_rdata, .cfg, .bus_wdata,
      .core_rdata);
   pabw_mem_model mem (.pclk, .acc, .acc_rdata);
   // Lane swap for the expected words
   function automatic logic [31:0] sw(input logic e, input logic [31:0] w);
      return e ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
   endfunction
   task automatic cmp_bus(input logic [67:0] e, input logic [67:0] a);
      samples_checked++;
      if (e !== a) begin
         error_cnt++;
         $display("FAIL %0t exp=%h got=%h", $time, e, a);
      end
   endtask
   task automatic cmp_reg(input logic [31:0] e, input logic [31:0] a);
      cmp_bus({36'h0, e}, {36'h0, a});
   endtask
   task automatic end_sim();
      $display("checks=%0d mismatches=%0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // APB master: setup, then access until pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v, input logic [3:0] s);
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= {20'h0, a};
      pwdata <= v;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 0;
      penable <= 0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      rd_q.push_back(e);
      apb(0, a, 32'h0, HALFWORD_STRB);
   endtask
   // Watcher: compares results against the oldest note, and bounds the run
   always @(posedge pclk) begin
      if (psel && penable && !pwrite) cmp_reg(rd_q.pop_front(), prdata);
      if (bus_chk) begin
         x = bq.pop_front();
         cmp_bus({x, sw(x[33], acc_rdata)}, {cfg, bus_wdata, core_rdata});
      end
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         end_sim();
      end
   end
   // Main sequence
   initial begin
      d = $urandom(32'hc0d2);
      repeat (3) @(posedge pclk);
      presetn <= 1;
      repeat (4) @(posedge pclk);
      rd(BUS_WIDTH_CONFIG_ADDR, 32'h5555);
      rd(BYTE_ORDER_CONFIG_ADDR, 32'h0);
      $display("test reset_values done");
      apb(1, BUS_WIDTH_CONFIG_ADDR, {16'h0, wv}, HALFWORD_STRB);
      rd(BUS_WIDTH_CONFIG_ADDR, {16'h0, wv});
      d = ($urandom | 32'h1) & ~32'h4000;
      ov = d[15:0] & BYTE_ORDER_MASK;
      apb(1, BYTE_ORDER_CONFIG_ADDR, d, HALFWORD_STRB);
      apb(1, BYTE_ORDER_CONFIG_ADDR, ~d, 4'h1);
      rd(BYTE_ORDER_CONFIG_ADDR, {16'h0, ov});
      rd(12'h004, 32'h0);
      $display("test registers done");
      // Every area with every fixed and fetch combination
      for (int k = 0; k < 8; k++) begin
         for (int m = 0; m < 4; m++) begin
            d = $urandom;
            b = ov[2*k] & (m == 0);
            @(posedge pclk);
            acc <= {8'h01 << k, m[1:0]};
            acc_wdata <= d;
            bus_chk <= 1;
            bq.push_back({wv[2*k+:2], b, wv[2*k+:2] == 2'h3, sw(b, d)});
         end
      end
      @(posedge pclk);
      bus_chk <= 0;
      @(posedge pclk);
      $display("test bus_steering done");
      end_sim();
   end
endmodule
